//--- core/mdaw_fifo.sv
`timescale 1ns/100ps
`default_nettype none
// first-word-fall-through fifo; output stage is a register so memory
// latency shows as one idle cycle of out_valid after each pop
module mdaw_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  logic [WIDTH-1:0] rdata;
  logic             pend;
  wire  [AW:0]      fill  = wptr - rptr;
  wire              full  = (fill == (AW+1)'(DEPTH));
  wire              empty = (fill == '0);
  wire              push  = in_valid && !full;
  wire              pop_o = out_valid && out_ready;
  wire              fetch = !empty && !pend && (!out_valid || pop_o);
  assign in_ready = !full;
  mdaw_fifo_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk   (clk),
    .we    (push),
    .waddr (wptr[AW-1:0]),
    .wdata (in_data),
    .raddr (rptr[AW-1:0]),
    .rdata (rdata)
  );
  // pointers and output register; a fetch waits one cycle for memory
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr      <= '0;
      rptr      <= '0;
      pend      <= 1'b0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      pend <= fetch;
      if (fetch) begin
        rptr <= rptr + 1'b1;
      end
      if (pend) begin
        out_valid <= 1'b1;
        out_data  <= rdata;
      end else if (pop_o) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- core/mdaw_fifo_mem.sv
`timescale 1ns/100ps
`default_nettype none
// small word store, registered read data
module mdaw_fifo_mem #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output var  logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  // write and registered read
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

//--- core/mdaw_master.sv
`timescale 1ns/100ps
`default_nettype none
// local master sequencer for a dual address burst write on the PCI bus
module mdaw_master (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  // local master side
  input  wire logic        LOCAL_REQ_32BIT_N,
  output var  logic        LOCAL_GRANT_N,
  input  wire logic [31:0] L_AD_IN,
  input  wire logic [3:0]  LOCAL_CMD_BYTE_EN_IN,
  input  wire logic [15:0] LOCAL_BURST_LENGTH,
  input  wire logic        LOCAL_READY_N,
  output var  logic        LOCAL_XFER_STROBE_N,
  output var  logic [3:0]  LOCAL_MASTER_STATE,
  output var  logic [1:0]  LOCAL_TERM_REASON,
  output var  logic [15:0] LOCAL_BURST_REMAINING,
  // pci side
  output var  logic        REQ_N,
  input  wire logic        GNT_N,
  input  wire logic        FRAME_N_IN,
  input  wire logic        IRDY_N_IN,
  input  wire logic        TRDY_N,
  output var  logic        FRAME_N_OUT,
  output var  logic        FRAME_N_OE,
  output var  logic        IRDY_N_OUT,
  output var  logic        IRDY_N_OE,
  output var  logic [31:0] AD_OUT,
  output var  logic        AD_OE,
  output var  logic [3:0]  CBE_N_OUT,
  output var  logic        CBE_N_OE
);
  // bus pins share SYS_CLK, so they are sampled directly; a
  // synchroniser would report completed data phases cycles late
  wire gnt_q  = GNT_N;
  wire frm_q  = FRAME_N_IN;
  wire irdy_q = IRDY_N_IN;
  wire trdy_q = TRDY_N;

  // asserted means low on every _n signal
  wire gnt_on   = !gnt_q;
  wire trdy_on  = !trdy_q;
  wire bus_idle = frm_q && irdy_q;
  wire req_on   = !LOCAL_REQ_32BIT_N;
  wire rdy_on   = !LOCAL_READY_N;

  mdaw_pkg::mdaw_state_type state;
  mdaw_pkg::mdaw_state_type next_state;
  logic [31:0]  addr_lo;
  logic [3:0]   cmd;
  logic [15:0]  len;
  logic         req_q;
  logic         frm_prev;
  logic [15:0]  remain;
  logic [15:0]  taken;
  logic [3:0]   in_fifo;

  // data fifo between local inputs and the bus
  logic         f_in_ready;
  logic         f_out_valid;
  logic [35:0]  f_out_data;
  wire          data_phase = (state == mdaw_pkg::S_DATA);
  wire          phase_done = data_phase && !IRDY_N_OUT && trdy_on;
  wire          last_phase = phase_done && (remain == 16'h0001);
  wire [15:0]   remain_next = remain - {15'h0000, phase_done};
  // strobe low: the word on the local inputs is taken at this edge
  wire          take_now = !LOCAL_XFER_STROBE_N;
  // ad is free when empty or when its word completes now
  wire          ad_free  = IRDY_N_OUT || phase_done;
  wire          to_bus   = (next_state == mdaw_pkg::S_DATA) && ad_free;
  wire          pop_word = to_bus && f_out_valid;
  // an empty fifo is skipped so the first word meets the first data phase
  wire          bypass   = to_bus && !f_out_valid && take_now &&
                           (in_fifo == 4'h0);
  wire          push     = take_now && !bypass;
  wire          irdy_next = pop_word || bypass ||
                            (!IRDY_N_OUT && !phase_done);
  wire [3:0]    in_fifo_next = in_fifo + {3'h0, push} - {3'h0, pop_word};
  wire [15:0]   taken_next = taken + {15'h0000, take_now};
  wire          xfer_window = (next_state == mdaw_pkg::S_ADDR_HI) ||
                              (next_state == mdaw_pkg::S_DATA);
  // counting fifo words keeps a strobed word from meeting a full fifo
  wire          next_take = xfer_window && rdy_on && f_in_ready &&
                            (in_fifo_next < 4'h8) && (taken_next < len);

  mdaw_fifo #(.WIDTH(36), .DEPTH(mdaw_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (SYS_CLK),
    .rst_n     (RESET_N),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .in_data   ({LOCAL_CMD_BYTE_EN_IN, L_AD_IN}),
    .out_valid (f_out_valid),
    .out_ready (pop_word),
    .out_data  (f_out_data)
  );

  // next state decode
  always_comb begin
    next_state = state;
    case (state)
      mdaw_pkg::S_IDLE: begin
        if (req_on) next_state = mdaw_pkg::S_REQ;
      end
      mdaw_pkg::S_REQ: begin
        if (gnt_on && bus_idle) next_state = mdaw_pkg::S_GRANT;
      end
      mdaw_pkg::S_GRANT: begin
        if (req_on && !LOCAL_GRANT_N) next_state = mdaw_pkg::S_LOAD;
      end
      mdaw_pkg::S_LOAD: begin
        next_state = mdaw_pkg::S_ADDR_LO;
      end
      mdaw_pkg::S_ADDR_LO: begin
        next_state = mdaw_pkg::S_ADDR_HI;
      end
      mdaw_pkg::S_ADDR_HI: begin
        next_state = mdaw_pkg::S_DATA;
      end
      mdaw_pkg::S_DATA: begin
        if (last_phase) next_state = mdaw_pkg::S_TURN;
      end
      mdaw_pkg::S_TURN: begin
        next_state = mdaw_pkg::S_IDLE;
      end
      default: begin
        next_state = mdaw_pkg::S_IDLE;
      end
    endcase
  end

  // state register and delayed samples
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      state     <= mdaw_pkg::S_IDLE;
      req_q     <= 1'b0;
      frm_prev  <= 1'b0;
    end else begin
      state     <= next_state;
      req_q     <= req_on;
      frm_prev  <= !FRAME_N_OUT;
    end
  end

  // latch address, command and burst length at load
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      addr_lo <= 32'h0000_0000;
      cmd     <= 4'h0;
      len     <= mdaw_pkg::LEN_RESET;
    end else if (state == mdaw_pkg::S_GRANT && next_state == mdaw_pkg::S_LOAD) begin
      addr_lo <= L_AD_IN;
      cmd     <= LOCAL_CMD_BYTE_EN_IN;
      len     <= LOCAL_BURST_LENGTH;
    end
  end

  // arbitration: request on local request, release once frame seen
  // after the local request was withdrawn
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      REQ_N         <= 1'b1;
      LOCAL_GRANT_N <= 1'b1;
    end else begin
      if (state == mdaw_pkg::S_IDLE && req_on) begin
        REQ_N <= 1'b0;
      end else if (frm_prev && !req_q && !REQ_N) begin
        REQ_N <= 1'b1;
      end
      // grant only with gntn and an idle bus
      LOCAL_GRANT_N <= !(next_state == mdaw_pkg::S_GRANT);
    end
  end

  // remaining count: load in low address phase, decrement per phase
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      remain <= mdaw_pkg::LEN_RESET;
    end else if (state == mdaw_pkg::S_LOAD) begin
      remain <= len;
    end else if (phase_done && remain != 16'h0000) begin
      remain <= remain - 16'h0001;
    end
  end

  // words strobed so far and words waiting in the fifo
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      taken   <= 16'h0000;
      in_fifo <= 4'h0;
    end else if (state == mdaw_pkg::S_LOAD) begin
      taken   <= 16'h0000;
      in_fifo <= 4'h0;
    end else begin
      taken   <= taken_next;
      in_fifo <= in_fifo_next;
    end
  end

  // pci drive: frame, irdy, ad and cbe
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      FRAME_N_OUT <= 1'b1;
      FRAME_N_OE  <= 1'b0;
      IRDY_N_OUT  <= 1'b1;
      IRDY_N_OE   <= 1'b0;
      AD_OUT      <= 32'h0000_0000;
      AD_OE       <= 1'b0;
      CBE_N_OUT   <= 4'hf;
      CBE_N_OE    <= 1'b0;
    end else begin
      case (next_state)
        mdaw_pkg::S_ADDR_LO: begin
          FRAME_N_OUT <= 1'b0;
          FRAME_N_OE  <= 1'b1;
          AD_OUT      <= addr_lo;
          AD_OE       <= 1'b1;
          CBE_N_OUT   <= cmd;
          CBE_N_OE    <= 1'b1;
        end
        mdaw_pkg::S_ADDR_HI: begin
          AD_OUT    <= L_AD_IN;
          CBE_N_OUT <= cmd;
        end
        mdaw_pkg::S_DATA: begin
          // words remain: keep frame; it rises with the last word
          FRAME_N_OUT <= (remain_next == 16'h0001) &&
                         irdy_next;
          IRDY_N_OE   <= 1'b1;
          // irdy held while a word waits on ad
          IRDY_N_OUT  <= !irdy_next;
          if (pop_word) begin
            AD_OUT    <= f_out_data[31:0];
            CBE_N_OUT <= f_out_data[35:32];
          end else if (bypass) begin
            AD_OUT    <= L_AD_IN;
            CBE_N_OUT <= LOCAL_CMD_BYTE_EN_IN;
          end
        end
        mdaw_pkg::S_TURN: begin
          // release frame, ad and cbe; irdy driven high one cycle
          FRAME_N_OUT <= 1'b1;
          FRAME_N_OE  <= 1'b0;
          AD_OE       <= 1'b0;
          CBE_N_OE    <= 1'b0;
          IRDY_N_OUT  <= 1'b1;
        end
        default: begin
          FRAME_N_OUT <= 1'b1;
          FRAME_N_OE  <= 1'b0;
          IRDY_N_OUT  <= 1'b1;
          IRDY_N_OE   <= 1'b0;
          AD_OE       <= 1'b0;
          CBE_N_OE    <= 1'b0;
        end
      endcase
    end
  end

  // local status, strobe and counter copy
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      LOCAL_MASTER_STATE    <= mdaw_pkg::ST_IDLE;
      LOCAL_TERM_REASON     <= mdaw_pkg::TERM_NONE;
      LOCAL_XFER_STROBE_N   <= 1'b1;
      LOCAL_BURST_REMAINING <= mdaw_pkg::LEN_RESET;
    end else begin
      LOCAL_BURST_REMAINING <= remain;
      // strobe marks words taken from the local inputs; already high by the last phase
      // strobe for the coming cycle, none past the burst length
      LOCAL_XFER_STROBE_N <= !next_take;
      case (next_state)
        mdaw_pkg::S_LOAD, mdaw_pkg::S_ADDR_LO: begin
          LOCAL_MASTER_STATE <= mdaw_pkg::ST_ADDR_LOAD;
          LOCAL_TERM_REASON  <= mdaw_pkg::TERM_NONE;
        end
        mdaw_pkg::S_ADDR_HI, mdaw_pkg::S_DATA: begin
          LOCAL_MASTER_STATE <= mdaw_pkg::ST_BUS_XACT;
        end
        mdaw_pkg::S_TURN: begin
          LOCAL_MASTER_STATE <= mdaw_pkg::ST_BUS_TERM;
          LOCAL_TERM_REASON  <= mdaw_pkg::TERM_NORMAL;
        end
        default: begin
          LOCAL_MASTER_STATE <= mdaw_pkg::ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- core/mdaw_pkg.sv
// Summary of operation
// - on seeing the local request the core asserts PCI reqn
// - with gntn asserted and bus idle the core asserts local grant
// - request and grant both seen last cycle: state Address Loading, latch inputs
// - after Address Loading core asserts framen; local master drops its request
// - low address phase drives low address and DAC command, state stays loading
// - low address phase loads the remaining-burst counter with burst length
// - reqn released when framen was asserted and local request already withdrawn
// - high address phase drives upper address and command, state Bus Transaction
// - with ready before first data phase, first word taken under transfer strobe
// - first data phase keeps framen, asserts irdyn, drops strobe when not taking
// - phase completes with irdyn and trdyn low; counter then decrements
// - after target accepts a word the next buffered word goes onto ad/cben
// - irdyn stays asserted when local ready was asserted the previous cycle; core holds it only while a word waits on ad, so it drops after zero-wait fifo words
// - ready and trdyn both low last cycle: strobe asserted to take next word; core ignores trdyn, strobes on ready while fifo room and words remain
// - framen stays asserted while words remain in the burst
// - final data phase deasserts framen and drops the transfer strobe
// - turnaround after last phase: state Bus Termination, normal termination reported
package mdaw_pkg;
  localparam int DATA_W    = 32;
  localparam int BE_W      = 4;
  localparam int LEN_W     = 16;
  localparam int FIFO_DEPTH = 8;
  // local state codes seen by the local master
  localparam logic [3:0] ST_IDLE     = 4'h0;
  localparam logic [3:0] ST_ADDR_LOAD = 4'h1;
  localparam logic [3:0] ST_BUS_XACT = 4'h2;
  localparam logic [3:0] ST_BUS_TERM = 4'h3;
  // termination reasons
  localparam logic [1:0] TERM_NONE   = 2'h0;
  localparam logic [1:0] TERM_NORMAL = 2'h1;
  localparam logic [LEN_W-1:0] LEN_RESET = 16'h0000;
  typedef enum {S_IDLE, S_REQ, S_GRANT, S_LOAD, S_ADDR_LO, S_ADDR_HI,
                S_DATA, S_TURN} mdaw_state_type;
endpackage

//--- testbench/master_dual_address_write_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module master_dual_address_write_tb_top;
  localparam logic [3:0] DAC_CMD = 4'hd;  // dual address command code
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        req_n = 1'b1;
  logic        ready_n = 1'b1;
  logic        stall = 1'b0;
  logic        fr_q = 1'b1;
  logic        hi_ph = 1'b0;
  logic [31:0] l_ad = 32'h0;
  logic [3:0]  cbe_in = 4'h0;
  logic [15:0] burst_len = 16'h0;
  logic [31:0] rng = 32'h0001_1194;
  logic        grant_n, strobe_n, req_pci_n, gnt_n, frame_in, irdy_in;
  logic        trdy_n, frame_out, frame_oe, irdy_out, irdy_oe, ad_oe;
  logic        cbe_oe, done;
  logic [3:0]  state, cbe_out;
  logic [1:0]  term;
  logic [15:0] remain;
  logic [31:0] ad_out;
  logic [35:0] s;
  logic [36:0] e;
  logic [36:0] exp_q[$];
  int          lens[4] = '{1, 3, 12, 20};
  int          modes[4] = '{0, 0, 1, 2};
  int          bad_count = 0;
  int          samples_checked = 0;

  mdaw_master i_mdaw_master (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .LOCAL_REQ_32BIT_N(req_n),
    .LOCAL_GRANT_N(grant_n), .L_AD_IN(l_ad), .LOCAL_CMD_BYTE_EN_IN(cbe_in),
    .LOCAL_BURST_LENGTH(burst_len), .LOCAL_READY_N(ready_n),
    .LOCAL_XFER_STROBE_N(strobe_n), .LOCAL_MASTER_STATE(state),
    .LOCAL_TERM_REASON(term), .LOCAL_BURST_REMAINING(remain),
    .REQ_N(req_pci_n), .GNT_N(gnt_n), .FRAME_N_IN(frame_in),
    .IRDY_N_IN(irdy_in), .TRDY_N(trdy_n), .FRAME_N_OUT(frame_out),
    .FRAME_N_OE(frame_oe), .IRDY_N_OUT(irdy_out), .IRDY_N_OE(irdy_oe),
    .AD_OUT(ad_out), .AD_OE(ad_oe), .CBE_N_OUT(cbe_out), .CBE_N_OE(cbe_oe)
  );
  mdaw_target_model i_mdaw_target_model (
    .sys_clk(sys_clk), .reset_n(reset_n), .req_n(req_pci_n),
    .frame_n_out(frame_out), .frame_n_oe(frame_oe), .irdy_n_out(irdy_out),
    .irdy_n_oe(irdy_oe), .stall(stall), .gnt_n(gnt_n), .frame_n_in(frame_in),
    .irdy_n_in(irdy_in), .trdy_n(trdy_n), .done(done)
  );

  always #2 sys_clk = ~sys_clk;

  function logic [31:0] xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task step();
    @(posedge sys_clk);
    #1;
  endtask
  task check(input string what, input logic [35:0] seen,
             input logic [35:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask
  task conclude();
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function bit hit(input int w);
    case (w)
      0: hit = grant_n === 1'b0;
      1: hit = frame_out === 1'b0 && frame_oe === 1'b1;
      2: hit = state === mdaw_pkg::ST_BUS_TERM;
      default: hit = state === mdaw_pkg::ST_IDLE;
    endcase
  endfunction
  // every wait is bounded; running out ends the run
  task wait_hit(input int w);
    int k;
    k = 0;
    while (!hit(w) && k < 400) begin
      step();
      k++;
    end
    if (k == 400) begin
      check("wait", 36'(w), 36'hf);
      conclude();
    end
  endtask

  // local master: request, high address, then words under the strobe
  task automatic burst(input logic [15:0] len, input int mode);
    int n;
    int k;
    logic tk;
    n = 0;
    k = 0;
    req_n = 1'b0;
    l_ad = xorshift();
    cbe_in = DAC_CMD;
    burst_len = len;
    exp_q.push_back({1'b1, l_ad, DAC_CMD});
    wait_hit(0);
    step();
    req_n = 1'b1;
    wait_hit(1);
    l_ad = xorshift();
    exp_q.push_back({1'b0, l_ad, 4'h0});
    ready_n = 1'b0;
    step();
    l_ad = xorshift();
    cbe_in = rng[7:4];
    while (n < len && k < 1000) begin
      tk = strobe_n === 1'b0;
      step();
      k++;
      if (tk) begin
        exp_q.push_back({1'b1, l_ad, cbe_in});
        n++;
        l_ad = xorshift();
        cbe_in = rng[7:4];
      end
      // mode 2 stalls the target long enough to fill the buffer
      if (mode == 2) stall = k < 40;
      else stall = mode == 1 && xorshift() < 32'h4000_0000;
      if (mode == 2 && k == 40) check("fill", 36'(n), 36'(8 + (n > 8)));
    end
    ready_n = 1'b1;
    stall = 1'b0;
    check("words", 36'(n), 36'(len));
    wait_hit(2);
    check("term", 36'(term), 36'(mdaw_pkg::TERM_NORMAL));
    repeat (2) step();
    check("remain", 36'(remain), 36'h0);
    check("left", 36'(exp_q.size()), 36'h0);
    wait_hit(3);
  endtask

  // compares each address phase and completed data phase with a note
  always @(posedge sys_clk) begin
    hi_ph <= reset_n && fr_q && !frame_in;
    fr_q  <= frame_in;
    if (reset_n && ((fr_q && !frame_in) || hi_ph || done)) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 37'h0;
      s = {ad_out, e[36] ? cbe_out : e[3:0]};
      check("phase", s, e[35:0]);
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    s = {27'h0, state, req_pci_n, frame_oe, irdy_oe, ad_oe, strobe_n};
    check("reset", s, 36'h11);
    for (int t = 0; t < 4; t++) begin
      burst(16'(lens[t]), modes[t]);
      $display("test %0d done, burst of %0d", t, lens[t]);
    end
    conclude();
  end
endmodule
`default_nettype wire

//--- testbench/mdaw_master_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// port-side checks on the local handshake and the pci drive
module mdaw_master_asserts (
  input wire logic        SYS_CLK,
  input wire logic        RESET_N,
  input wire logic        LOCAL_REQ_32BIT_N,
  input wire logic        LOCAL_GRANT_N,
  input wire logic [15:0] LOCAL_BURST_LENGTH,
  input wire logic        LOCAL_READY_N,
  input wire logic        LOCAL_XFER_STROBE_N,
  input wire logic [3:0]  LOCAL_MASTER_STATE,
  input wire logic [1:0]  LOCAL_TERM_REASON,
  input wire logic [15:0] LOCAL_BURST_REMAINING,
  input wire logic        REQ_N,
  input wire logic        FRAME_N_OUT,
  input wire logic        FRAME_N_OE,
  input wire logic        IRDY_N_OUT,
  input wire logic        IRDY_N_OE,
  input wire logic        AD_OE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // decoded views of state and frame drive
  wire frame_low = FRAME_N_OE && !FRAME_N_OUT;
  wire st_idle   = LOCAL_MASTER_STATE == mdaw_pkg::ST_IDLE;
  wire st_load   = LOCAL_MASTER_STATE == mdaw_pkg::ST_ADDR_LOAD;
  wire st_xact   = LOCAL_MASTER_STATE == mdaw_pkg::ST_BUS_XACT;
  wire st_term   = LOCAL_MASTER_STATE == mdaw_pkg::ST_BUS_TERM;
  // low address phase, then high address phase
  sequence s_low_addr; st_load && frame_low; endsequence
  sequence s_high_addr; st_xact && AD_OE && frame_low; endsequence

  a_req_to_pci: assert property ($fell(LOCAL_REQ_32BIT_N) && st_idle
    |-> ##[1:2] !REQ_N) else $error("pci request not raised");
  a_grant_one_cycle: assert property ($fell(LOCAL_GRANT_N)
    |=> LOCAL_GRANT_N) else $error("local grant longer than a cycle");
  a_load_after_grant: assert property (!LOCAL_GRANT_N &&
    !LOCAL_REQ_32BIT_N |-> ##[1:2] st_load) else $error("no load state");
  a_frame_after_load: assert property (st_load && !frame_low
    |=> s_low_addr) else $error("low address phase missing");
  a_high_then_data: assert property (s_low_addr
    |=> s_high_addr ##1 (IRDY_N_OE && !IRDY_N_OUT))
    else $error("high address or first data phase wrong");
  a_count_loaded: assert property (s_low_addr
    |-> ##[1:2] LOCAL_BURST_REMAINING == LOCAL_BURST_LENGTH)
    else $error("burst counter not loaded");
  a_req_release: assert property (frame_low && LOCAL_REQ_32BIT_N
    |-> ##[1:2] REQ_N) else $error("pci request not released");
  a_frame_kept: assert property (frame_low && st_xact &&
    LOCAL_BURST_REMAINING > 16'h0003 |=> !FRAME_N_OUT)
    else $error("frame dropped with words left");
  a_strobe_ready: assert property (!LOCAL_XFER_STROBE_N
    |-> !LOCAL_READY_N || !$past(LOCAL_READY_N))
    else $error("word taken without ready");
  a_term_normal: assert property (st_term
    |-> LOCAL_TERM_REASON == mdaw_pkg::TERM_NORMAL && !frame_low)
    else $error("termination reported wrongly");
endmodule
bind mdaw_master mdaw_master_asserts i_mdaw_master_asserts (.*);
`default_nettype wire

//--- testbench/mdaw_target_model.sv
`timescale 1ns/100ps
`default_nettype none
// arbiter plus write target on the far side of the pci pins
module mdaw_target_model (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic req_n,
  input  wire logic frame_n_out,
  input  wire logic frame_n_oe,
  input  wire logic irdy_n_out,
  input  wire logic irdy_n_oe,
  input  wire logic stall,
  output var  logic gnt_n,
  output var  logic frame_n_in,
  output var  logic irdy_n_in,
  output var  logic trdy_n,
  output var  logic done
);
  logic [1:0] phase;
  // released lines float up on the bus pull-ups
  assign frame_n_in = frame_n_oe ? frame_n_out : 1'b1;
  assign irdy_n_in  = irdy_n_oe ? irdy_n_out : 1'b1;
  // no claim during the two address phases; stall holds data off
  assign trdy_n = !(phase == 2'h2 && !(frame_n_in && irdy_n_in) && !stall);
  assign done   = !irdy_n_in && !trdy_n;
  // grant trails the request by a cycle
  always_ff @(posedge sys_clk) begin
    gnt_n <= !reset_n || req_n;
    if (!reset_n || (frame_n_in && irdy_n_in)) begin
      phase <= 2'h0;
    end else if (phase != 2'h2) begin
      phase <= phase + 2'h1;
    end
  end
endmodule
`default_nettype wire
